// ==== include/cbr_pkg.sv ====
// Purpose: Shared constants and types for the bit-logic, stack and rotate execution unit.
// Assumes: One core clock, synchronous active-low reset.
// Notes:   Opcodes are the one-byte encodings of the operations this unit executes.
package cbr_pkg;

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_OR_DIR_ACC  = 8'h42;
  localparam logic [7:0] OP_OR_DIR_IMM  = 8'h43;
  localparam logic [7:0] OP_OR_C_BIT    = 8'h72;
  localparam logic [7:0] OP_OR_C_NBIT   = 8'ha0;
  localparam logic [7:0] OP_POP         = 8'hd0;
  localparam logic [7:0] OP_PUSH        = 8'hc0;
  localparam logic [7:0] OP_SUB_RET     = 8'h22;
  localparam logic [7:0] OP_INT_RET     = 8'h32;
  localparam logic [7:0] OP_ROT_L       = 8'h23;
  localparam logic [7:0] OP_ROT_LC      = 8'h33;
  localparam logic [7:0] OP_ROT_R       = 8'h03;
  localparam logic [7:0] OP_ROT_RC      = 8'h13;
  localparam logic [7:0] OP_SET_C       = 8'hd3;
  localparam logic [7:0] OP_SET_BIT     = 8'hd2;
  localparam logic [7:0] OP_SHORT_JUMP  = 8'h80;

  // ************************************************************
  // Addresses, reset values and arithmetic constants
  // ************************************************************
  localparam logic [7:0]  STACK_POINTER_ADDR = 8'h81;
  localparam logic [7:0]  BIT_AREA_BASE      = 8'h20;
  localparam logic [7:0]  SFR_BIT_LIMIT      = 8'h80;
  localparam logic [7:0]  SP_RESET           = 8'h07;
  localparam logic [7:0]  ACC_RESET          = 8'h00;
  localparam logic [15:0] PC_RESET           = 16'h0000;
  localparam logic [7:0]  SP_STEP            = 8'h01;
  localparam logic [15:0] PC_SHORT_ADVANCE   = 16'h0002;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_EX1, ST_EX2} cbr_state_e;

  typedef struct packed {
    logic        start;
    logic [7:0]  opcode;
    logic [7:0]  arg1;
    logic [7:0]  arg2;
    logic [15:0] insn_pc;
  } cbr_req_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       idata;
    logic       latch;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbr_mem_s;

  typedef struct packed {
    cbr_state_e  st;
    logic [7:0]  op;
    logic [7:0]  a1;
    logic [7:0]  a2;
    logic [7:0]  tmp;
    logic [7:0]  acc;
    logic        cy;
    logic [7:0]  sp;
    logic [15:0] pc;
    logic        hold;
    logic        rel;
  } cbr_core_s;

  localparam cbr_core_s CORE_RESET = '{st: ST_IDLE, op: 8'h00, a1: 8'h00, a2: 8'h00,
                                       tmp: 8'h00, acc: ACC_RESET, cy: 1'b0, sp: SP_RESET,
                                       pc: PC_RESET, hold: 1'b0, rel: 1'b0};

endpackage

// ==== core/cbr_alu.sv ====
// Purpose: Accumulator rotates and bit-address decoding for the execution unit.
// Assumes: Purely combinational; opcode selects the rotate.
// Notes:   Non-rotate opcodes pass accumulator and carry through unchanged.
`timescale 1ns/1ps
module cbr_alu (
  input  wire logic [7:0] op,
  input  wire logic [7:0] acc,
  input  wire logic       cy,
  input  wire logic [7:0] bit_addr,
  output logic      [7:0] acc_out,
  output logic            cy_out,
  output logic      [7:0] bit_byte,
  output logic      [7:0] bit_mask
);

  // ************************************************************
  // Rotates
  // ************************************************************
  always_comb
  begin
    acc_out = acc;
    cy_out  = cy;
    case (op)
      cbr_pkg::OP_ROT_L:  acc_out = {acc[6:0], acc[7]};                      // RULE10
      cbr_pkg::OP_ROT_LC:
      begin
        acc_out = {acc[6:0], cy};                                            // RULE11
        cy_out  = acc[7];                                                    // RULE11
      end
      cbr_pkg::OP_ROT_R:  acc_out = {acc[0], acc[7:1]};                      // RULE12
      cbr_pkg::OP_ROT_RC:
      begin
        acc_out = {cy, acc[7:1]};                                            // RULE13
        cy_out  = acc[0];                                                    // RULE13
      end
      default:
      begin
        acc_out = acc;
        cy_out  = cy;
      end
    endcase
  end

  // ************************************************************
  // Bit address to byte address and mask
  // ************************************************************
  always_comb
  begin
    if (bit_addr < cbr_pkg::SFR_BIT_LIMIT)
      bit_byte = cbr_pkg::BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
    else
      bit_byte = {bit_addr[7:3], 3'h0};
    bit_mask = 8'h01 << bit_addr[2:0];
  end

endmodule // cbr_alu

// ==== core/cbr_exec.sv ====
// Purpose: Executes OR, bit-OR to carry, push, pop, returns, rotates, set-bit and short jump.
// Assumes: Memory read data is returned in the same cycle as the read strobe.
// Notes:   A read and a write to one address in one cycle form a read-modify-write.
`timescale 1ns/1ps

// Operation
// RULE1 - Bit-OR into carry sets carry when source bit is one; two cycles.
// RULE2 - Complemented form uses inverted bit; addressed bit stays unchanged.
// RULE3 - Pop reads stack byte, decrements pointer, writes direct byte; two cycles.
// RULE4 - Pop into the stack pointer leaves the popped value as pointer.
// RULE5 - Push increments pointer, then stores the direct byte there; two cycles.
// RULE6 - Subroutine return pops high then low PC byte, pointer minus two.
// RULE7 - Interrupt return restores PC and releases the serviced priority level.
// RULE8 - Interrupt return restores no status word or other register.
// RULE9 - After interrupt return one more instruction completes before pending service.
// RULE10 - Rotate left moves bit seven to bit zero, flags unchanged, one cycle.
// RULE11 - Rotate left through carry: bit seven to carry, carry to bit zero.
// RULE12 - Rotate right moves bit zero to bit seven, flags unchanged.
// RULE13 - Rotate right through carry: bit zero to carry, carry to bit seven.
// RULE14 - Set-bit forces carry or an addressed bit to one; carry form one cycle.
// RULE15 - Short jump adds signed displacement to PC plus two; two cycles.
// RULE16 - OR into a port reads the output latch, not the pins.
// RULE17 - Stack pointer steps wrap modulo 256 with no flag effects.
module cbr_exec (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire cbr_pkg::cbr_req_s req,
  input  wire logic             insn_retired,
  input  wire logic [7:0]       mem_rdata,
  output cbr_pkg::cbr_mem_s     mem,
  output logic                  ready,
  output logic                  done,
  output logic                  pc_load,
  output logic [15:0]           pc,
  output logic [7:0]            acc,
  output logic                  carry,
  output logic [7:0]            stack_pointer,
  output logic                  prio_release,
  output logic                  irq_hold
);

  cbr_pkg::cbr_core_s q;
  cbr_pkg::cbr_core_s d;
  logic [7:0]         rot_acc;
  logic               rot_cy;
  logic [7:0]         bit_byte;
  logic [7:0]         bit_mask;
  logic [7:0]         sp_inc;
  logic [7:0]         sp_dec;
  logic               src_bit;

  // ************************************************************
  // Rotate and bit decode unit
  // ************************************************************
  cbr_alu u_alu (
    .op       (q.op),
    .acc      (q.acc),
    .cy       (q.cy),
    .bit_addr (q.a1),
    .acc_out  (rot_acc),
    .cy_out   (rot_cy),
    .bit_byte (bit_byte),
    .bit_mask (bit_mask)
  );

  assign sp_inc  = q.sp + cbr_pkg::SP_STEP;                                  // RULE17
  assign sp_dec  = q.sp - cbr_pkg::SP_STEP;                                  // RULE17
  assign src_bit = |(q.tmp & bit_mask);

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    d       = q;
    d.rel   = 1'b0;
    mem     = '0;
    done    = 1'b0;
    pc_load = 1'b0;
    case (q.st)
      cbr_pkg::ST_IDLE:
      begin
        if (req.start)
        begin
          d.op = req.opcode;
          d.a1 = req.arg1;
          d.a2 = req.arg2;
          d.pc = req.insn_pc;
          d.st = cbr_pkg::ST_EX1;
        end
      end
      cbr_pkg::ST_EX1:
      begin
        d.st = cbr_pkg::ST_IDLE;
        done = 1'b1;
        case (q.op)
          cbr_pkg::OP_OR_DIR_ACC:
          begin
            mem.rd    = 1'b1;
            mem.wr    = 1'b1;
            mem.latch = 1'b1;                                                // RULE16
            mem.addr  = q.a1;
            mem.wdata = mem_rdata | q.acc;
          end
          cbr_pkg::OP_OR_C_BIT, cbr_pkg::OP_OR_C_NBIT:
          begin
            done     = 1'b0;
            mem.rd   = 1'b1;                                                 // RULE2
            mem.addr = bit_byte;
            d.tmp    = mem_rdata;
            d.st     = cbr_pkg::ST_EX2;
          end
          cbr_pkg::OP_POP:
          begin
            done      = 1'b0;
            mem.rd    = 1'b1;                                                // RULE3
            mem.idata = 1'b1;
            mem.addr  = q.sp;
            d.tmp     = mem_rdata;
            d.sp      = sp_dec;                                              // RULE3
            d.st      = cbr_pkg::ST_EX2;
          end
          cbr_pkg::OP_PUSH:
          begin
            done     = 1'b0;
            d.sp     = sp_inc;                                               // RULE5
            mem.rd   = 1'b1;
            mem.addr = q.a1;
            d.tmp    = mem_rdata;
            d.st     = cbr_pkg::ST_EX2;
          end
          cbr_pkg::OP_SUB_RET, cbr_pkg::OP_INT_RET:
          begin
            done       = 1'b0;
            mem.rd     = 1'b1;                                               // RULE6
            mem.idata  = 1'b1;
            mem.addr   = q.sp;
            d.pc[15:8] = mem_rdata;                                          // RULE6
            d.sp       = sp_dec;
            d.st       = cbr_pkg::ST_EX2;
          end
          cbr_pkg::OP_ROT_L, cbr_pkg::OP_ROT_LC, cbr_pkg::OP_ROT_R, cbr_pkg::OP_ROT_RC:
          begin
            d.acc = rot_acc;                                                 // RULE10
            d.cy  = rot_cy;                                                  // RULE11
          end
          cbr_pkg::OP_SET_C: d.cy = 1'b1;                                    // RULE14
          cbr_pkg::OP_SET_BIT:
          begin
            mem.rd    = 1'b1;                                                // RULE14
            mem.wr    = 1'b1;
            mem.latch = 1'b1;
            mem.addr  = bit_byte;
            mem.wdata = mem_rdata | bit_mask;
          end
          cbr_pkg::OP_OR_DIR_IMM, cbr_pkg::OP_SHORT_JUMP:
          begin
            done = 1'b0;
            d.st = cbr_pkg::ST_EX2;
          end
          default: d.st = cbr_pkg::ST_IDLE;
        endcase
      end
      cbr_pkg::ST_EX2:
      begin
        d.st = cbr_pkg::ST_IDLE;
        done = 1'b1;
        case (q.op)
          cbr_pkg::OP_OR_DIR_IMM:
          begin
            mem.rd    = 1'b1;
            mem.wr    = 1'b1;
            mem.latch = 1'b1;                                                // RULE16
            mem.addr  = q.a1;
            mem.wdata = mem_rdata | q.a2;
          end
          cbr_pkg::OP_OR_C_BIT:  d.cy = q.cy | src_bit;                      // RULE1
          cbr_pkg::OP_OR_C_NBIT: d.cy = q.cy | ~src_bit;                     // RULE2
          cbr_pkg::OP_POP:
          begin
            mem.wr    = 1'b1;                                                // RULE3
            mem.addr  = q.a1;
            mem.wdata = q.tmp;
            if (q.a1 == cbr_pkg::STACK_POINTER_ADDR)
              d.sp = q.tmp;                                                  // RULE4
          end
          cbr_pkg::OP_PUSH:
          begin
            mem.wr    = 1'b1;                                                // RULE5
            mem.idata = 1'b1;
            mem.addr  = q.sp;
            mem.wdata = q.tmp;
          end
          cbr_pkg::OP_SUB_RET, cbr_pkg::OP_INT_RET:
          begin
            mem.rd    = 1'b1;                                                // RULE6
            mem.idata = 1'b1;
            mem.addr  = q.sp;
            d.pc[7:0] = mem_rdata;
            d.sp      = sp_dec;                                              // RULE8
            pc_load   = 1'b1;
            d.rel     = (q.op == cbr_pkg::OP_INT_RET);                       // RULE7
          end
          cbr_pkg::OP_SHORT_JUMP:
          begin
            d.pc    = q.pc + cbr_pkg::PC_SHORT_ADVANCE + {{8{q.a2[7]}}, q.a2}; // RULE15
            pc_load = 1'b1;
          end
          default: d.st = cbr_pkg::ST_IDLE;
        endcase
      end
      default: d.st = cbr_pkg::ST_IDLE;
    endcase
    if (q.hold && ((done && q.op != cbr_pkg::OP_INT_RET) || insn_retired))
      d.hold = 1'b0;                                                         // RULE9
    if (done && q.op == cbr_pkg::OP_INT_RET)
      d.hold = 1'b1;                                                         // RULE9
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      q <= cbr_pkg::CORE_RESET;
    else
      q <= d;
  end

  assign ready         = (q.st == cbr_pkg::ST_IDLE);
  assign pc            = q.pc;
  assign acc           = q.acc;
  assign carry         = q.cy;
  assign stack_pointer = q.sp;
  assign prio_release  = q.rel;
  assign irq_hold      = q.hold;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_take(logic [7:0] o);
    ready && req.start && req.opcode == o;
  endsequence

  a_rot_left: assert property (s_take(cbr_pkg::OP_ROT_L) ##1 done |=>  // RULE10
      $past(acc, 2) == {acc[0], acc[7:1]} && carry == $past(carry, 2))
    else $error("rotate left result wrong");

  a_rot_rcarry: assert property (s_take(cbr_pkg::OP_ROT_RC) ##1 done |=>  // RULE13
      {acc[6:0], carry} == $past(acc, 2) && acc[7] == $past(carry, 2))
    else $error("rotate right through carry result wrong");

  a_rot_right: assert property (s_take(cbr_pkg::OP_ROT_R) ##1 done |=>  // RULE12
      $past(acc, 2) == {acc[6:0], acc[7]} && carry == $past(carry, 2))
    else $error("rotate right result wrong");

  a_rot_lcarry: assert property (s_take(cbr_pkg::OP_ROT_LC) ##1 done |=>  // RULE11
      {carry, acc} == {$past(acc, 2), $past(carry, 2)})
    else $error("rotate left through carry result wrong");

  a_push_step: assert property (s_take(cbr_pkg::OP_PUSH) |-> ##1 !done ##1  // RULE5
      (done && mem.wr && mem.idata && mem.addr == $past(stack_pointer, 2) + 8'h01))
    else $error("push did not store at incremented pointer");

  a_pop_order: assert property (s_take(cbr_pkg::OP_POP) |-> ##1  // RULE3
      (mem.rd && mem.idata && mem.addr == stack_pointer) ##1 (done && mem.wr && !mem.idata))
    else $error("pop sequence wrong");

  a_ret_sp: assert property (s_take(cbr_pkg::OP_SUB_RET) |-> ##3  // RULE6
      stack_pointer == $past(stack_pointer, 3) - 8'h02)
    else $error("return did not lower pointer by two");

  a_interrupt_return_op_release: assert property (s_take(cbr_pkg::OP_INT_RET) |-> ##3  // RULE7
      prio_release ##1 !prio_release)
    else $error("interrupt return did not release priority once");

  a_hold_after: assert property ($rose(prio_release) |-> irq_hold)  // RULE9
    else $error("hold missing after interrupt return");

  a_bit_set_op_carry: assert property (s_take(cbr_pkg::OP_SET_C) ##1 done |=> carry)  // RULE14
    else $error("carry not set");

  a_orc_keep: assert property (s_take(cbr_pkg::OP_OR_C_BIT) |-> ##1 !mem.wr ##1  // RULE1
      (done && !mem.wr) ##1 (carry == ($past(carry, 3) | $past(src_bit))))
    else $error("bit-or into carry wrong");

  a_short_relative_jump_op_pc: assert property (s_take(cbr_pkg::OP_SHORT_JUMP) |-> ##2 pc_load ##1  // RULE15
      pc == $past(req.insn_pc, 3) + 16'h0002
            + {{8{$past(req.arg2[7], 3)}}, $past(req.arg2, 3)})
    else $error("short jump target wrong");

  a_pop_sp: assert property (s_take(cbr_pkg::OP_POP) ##0  // RULE4
      (req.arg1 == cbr_pkg::STACK_POINTER_ADDR) |-> ##3 stack_pointer == $past(mem_rdata, 2))
    else $error("pop into pointer did not keep popped value");

  a_or_latch: assert property (s_take(cbr_pkg::OP_OR_DIR_ACC) |-> ##1  // RULE16
      (mem.rd && mem.wr && mem.latch && mem.addr == $past(req.arg1)))
    else $error("or into direct byte did not use the output latch");

  a_orc_inverse: assert property (s_take(cbr_pkg::OP_OR_C_NBIT) |-> ##1 !mem.wr ##1  // RULE2
      (done && !mem.wr) ##1 (carry == ($past(carry, 3) | ~$past(src_bit))))
    else $error("complemented bit-or into carry wrong");

endmodule // cbr_exec

// ==== tb/cbr_exec_tb.sv ====
// Purpose: Self-checking bench for the execution unit: rotates, bit logic, stack and jumps.
// Assumes: Memory answers reads combinationally; inputs change at the falling edge.
// Notes:   The bench holds internal RAM, direct space and one port's pin levels.
`timescale 1ns/1ps
module testbench;

  // ************************************************************
  // Signals
  // ************************************************************
  logic              clk;
  logic              rst_b;
  cbr_pkg::cbr_req_s req;
  logic              insn_retired;
  logic [7:0]        mem_rdata;
  cbr_pkg::cbr_mem_s mem;
  logic              ready;
  logic              done;
  logic              pc_load;
  logic [15:0]       pc;
  logic [7:0]        acc;
  logic              carry;
  logic [7:0]        stack_pointer;
  logic              prio_release;
  logic              irq_hold;
  logic [7:0]        iram [256];
  logic [7:0]        dmem [256];
  logic [7:0]        port_pins;
  int                mismatches;
  int                checks_done;
  int                cycles;

  cbr_exec uut (
    .clk           (clk),
    .rst_b         (rst_b),
    .req           (req),
    .insn_retired  (insn_retired),
    .mem_rdata     (mem_rdata),
    .mem           (mem),
    .ready         (ready),
    .done          (done),
    .pc_load       (pc_load),
    .pc            (pc),
    .acc           (acc),
    .carry         (carry),
    .stack_pointer (stack_pointer),
    .prio_release  (prio_release),
    .irq_hold      (irq_hold)
  );

  // ************************************************************
  // Clock, memory model and timeout
  // ************************************************************
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Port 90h returns its pins unless the access is a read-modify-write.
  assign mem_rdata = mem.idata ? iram[mem.addr] :
                     ((mem.addr == 8'h90) && !mem.latch) ? port_pins : dmem[mem.addr];

  always @(posedge clk)
  begin
    if (mem.wr && mem.idata)
      iram[mem.addr] <= mem.wdata;
    if (mem.wr && !mem.idata)
      dmem[mem.addr] <= mem.wdata;
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      final_report();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks done %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Issues one operation, waits for done and leaves one settled cycle after it.
  task automatic run_op(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2,
                        input logic [15:0] ipc, input int exp_cyc);
    int n;
    @(negedge clk);
    req = '{start: 1'b1, opcode: op, arg1: a1, arg2: a2, insn_pc: ipc};
    @(negedge clk);
    req.start = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'(exp_cyc));
    @(negedge clk);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_rotates();
    logic [7:0] ops [9] = '{8'hd3, 8'h33, 8'h03, 8'hd3, 8'h23, 8'h03, 8'h13, 8'h33, 8'h13};
    logic [7:0] accs [9] = '{8'h00, 8'h01, 8'h80, 8'h80, 8'h01, 8'h80, 8'hc0, 8'h80, 8'hc0};
    logic       cys [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 9; i++)
    begin
      run_op(ops[i], 8'h00, 8'h00, 16'h0000, 1);
      check({24'h0, acc}, {24'h0, accs[i]});
      check({31'h0, carry}, {31'h0, cys[i]});
    end
  endtask

  task automatic t_bit_or();
    dmem[8'h20] = 8'h01;
    run_op(8'ha0, 8'h00, 8'h00, 16'h0000, 2);
    check({31'h0, carry}, 32'h0);
    run_op(8'h72, 8'h01, 8'h00, 16'h0000, 2);
    check({31'h0, carry}, 32'h0);
    run_op(8'ha0, 8'h01, 8'h00, 16'h0000, 2);
    check({31'h0, carry}, 32'h1);
    check({24'h0, dmem[8'h20]}, 32'h01);
  endtask

  task automatic t_or_direct();
    dmem[8'h90] = 8'h30;
    port_pins = 8'h0f;
    run_op(8'h42, 8'h90, 8'h00, 16'h0000, 1);
    check({24'h0, dmem[8'h90]}, 32'hf0);
    dmem[8'h50] = 8'h10;
    run_op(8'h43, 8'h50, 8'h01, 16'h0000, 2);
    check({24'h0, dmem[8'h50]}, 32'h11);
    run_op(8'hd2, 8'h08, 8'h00, 16'h0000, 1);
    check({24'h0, dmem[8'h21]}, 32'h01);
    check({31'h0, carry}, 32'h1);
  endtask

  task automatic t_stack();
    dmem[8'h30] = 8'h5a;
    run_op(8'hc0, 8'h30, 8'h00, 16'h0000, 2);
    check({24'h0, stack_pointer}, 32'h08);
    check({24'h0, iram[8'h08]}, 32'h5a);
    run_op(8'hd0, 8'h40, 8'h00, 16'h0000, 2);
    check({24'h0, dmem[8'h40]}, 32'h5a);
    check({24'h0, stack_pointer}, 32'h07);
    iram[8'h07] = 8'h32;
    run_op(8'hd0, 8'h81, 8'h00, 16'h0000, 2);
    check({24'h0, stack_pointer}, 32'h32);
    iram[8'h32] = 8'h01;
    iram[8'h31] = 8'h23;
    run_op(8'h22, 8'h00, 8'h00, 16'h0000, 2);
    check({16'h0, pc}, 32'h0123);
    check({24'h0, stack_pointer}, 32'h30);
    check({30'h0, prio_release, irq_hold}, 32'h0);
  endtask

  task automatic t_int_return();
    iram[8'h30] = 8'h45;
    iram[8'h2f] = 8'h67;
    run_op(8'h32, 8'h00, 8'h00, 16'h0000, 2);
    check({16'h0, pc}, 32'h4567);
    check({24'h0, stack_pointer}, 32'h2e);
    check({31'h0, prio_release}, 32'h1);
    check({23'h0, acc, carry}, {23'h0, 8'hc0, 1'b1});
    @(negedge clk);
    check({31'h0, prio_release}, 32'h0);
    check({31'h0, irq_hold}, 32'h1);
    insn_retired = 1'b1;
    @(negedge clk);
    insn_retired = 1'b0;
    @(negedge clk);
    check({31'h0, irq_hold}, 32'h0);
    iram[8'h2e] = 8'hff;
    run_op(8'hd0, 8'h81, 8'h00, 16'h0000, 2);
    check({24'h0, stack_pointer}, 32'hff);
    run_op(8'hc0, 8'h30, 8'h00, 16'h0000, 2);
    check({24'h0, stack_pointer}, 32'h00);
    check({24'h0, iram[8'h00]}, 32'h5a);
  endtask

  task automatic t_short_jump();
    logic [15:0] ipcs [4] = '{16'h0100, 16'h0200, 16'h0200, 16'h0200};
    logic [7:0]  rels [4] = '{8'h21, 8'h80, 8'h7f, 8'hfe};
    logic [15:0] tgts [4] = '{16'h0123, 16'h0182, 16'h0281, 16'h0200};
    for (int i = 0; i < 4; i++)
    begin
      run_op(8'h80, 8'h00, rels[i], ipcs[i], 2);
      check({16'h0, pc}, {16'h0, tgts[i]});
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    rst_b = 1'b0;
    insn_retired = 1'b0;
    req = '0;
    port_pins = 8'h00;
    for (int i = 0; i < 256; i++)
    begin
      iram[i] = 8'h00;
      dmem[i] = 8'h00;
    end
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    check({23'h0, acc, carry}, 32'h0);
    check({24'h0, stack_pointer}, 32'h07);
    check({15'h0, pc, ready}, 32'h1);
    t_rotates();
    t_bit_or();
    t_or_direct();
    t_stack();
    t_int_return();
    t_short_jump();
    final_report();
  end

endmodule // testbench
